// >>> wsp_pkg.sv
// constants and types shared by the wiper serial slave port
package wsp_pkg;
	// width of the wiper setting and of one serial byte, then of the address and its fixed part
	localparam int             WIPER_W        = 8;
	localparam int             ADDR_W         = 7;
	localparam int             ADDR_FIXED_W   = 6;
	// value loaded at power-up and by the preset bit
	localparam logic [7:0]     MIDSCALE       = 8'h80;
	// code that sends the switch array to the b terminal in shutdown
	localparam logic [7:0]     SHUTDOWN_CODE  = 8'h00;
	// bit count at which a byte is complete
	localparam logic [3:0]     BYTE_BITS      = 4'h8;
	// instruction byte field positions
	localparam int             PRESET_POS     = 6;
	localparam int             SHUTDOWN_POS   = 5;
	// direction bit position in the address byte
	localparam int             DIR_POS        = 0;
	// synchroniser depth and lanes: scl, sda, address select
	localparam int             SYNC_STAGES    = 3;
	localparam int             SYNC_LANES     = 3;
	localparam int             LANE_SCL       = 0;
	localparam int             LANE_SDA       = 1;
	localparam int             LANE_ADSEL     = 2;

	// protocol phase of the slave
	typedef enum logic [2:0] {
		WSP_IDLE,
		WSP_ADDR,
		WSP_INSTR,
		WSP_WDATA,
		WSP_RDATA,
		WSP_RACK
	} wsp_state_t;
endpackage : wsp_pkg

// >>> wsp_serial_slave.sv
// two-wire serial slave port with wiper register, preset and shutdown
//
// Operation
// - detect sda falling while scl high as start, then receive address
// - first byte is seven address bits then direction, msb first
// - lowest address bit comes from the address select pin
// - ack a matching address on ninth clock; otherwise stay idle, sda released
// - direction high means read, low means write
// - second write byte is instruction; its msb and five lsbs ignored
// - preset bit high loads midscale 0x80 into the wiper register
// - shutdown bit high opens terminal a and ties wiper to b
// - shutdown keeps register contents; leaving it reapplies stored value
// - new wiper values are still accepted and stored during shutdown
// - after instruction ack, next byte is data; each byte is nine clocks
// - sda changes only while scl low, except start and stop
// - read: wiper byte shifts out right after address ack
// - sda rising while scl high is stop; return to idle
// - every further write data byte loads the wiper register
// - wiper register may be read repeatedly in one transaction
// - devices answer only their own address, set by select pin
// - power-up loads the wiper register with midscale
`timescale 1ns/100ps
`default_nettype none
module wsp_serial_slave #(
	parameter logic [wsp_pkg::ADDR_FIXED_W-1:0] ADDR_FIXED = 6'h16
) (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output var  logic                        sda_out,
	output var  logic                        sda_oe,
	input  wire logic                        addr_select_pin,
	output var  logic [wsp_pkg::WIPER_W-1:0] wiper_setting_register,
	output var  logic                        shutdown_bit,
	output var  logic [wsp_pkg::WIPER_W-1:0] wiper_drive
);
	import wsp_pkg::*;

	// the shift register and decode below assume byte-wide wiper and address
	if (WIPER_W != 8 || ADDR_W != ADDR_FIXED_W + 1) begin : g_bad_width
		$error("wiper serial slave supports only an 8-bit wiper and 7-bit address");
	end

	logic [SYNC_LANES-1:0]      raw_in;
	logic [SYNC_STAGES-1:0]     sync [SYNC_LANES];
	logic                       filt [SYNC_LANES];
	logic                       scl_prev;
	logic                       sda_prev;
	wsp_state_t                 state;
	wsp_state_t                 after_ack;
	logic                       ack_phase;
	logic                       master_ack;
	logic [3:0]                 bit_cnt;
	logic [WIPER_W-1:0]         shreg;

	assign raw_in[LANE_SCL]   = scl_in;
	assign raw_in[LANE_SDA]   = sda_in;
	assign raw_in[LANE_ADSEL] = addr_select_pin;

	// three-stage sampling; a level counts once stages two and three agree
	for (genvar i = 0; i < SYNC_LANES; i++) begin : g_sync
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				sync[i] <= '1;
				filt[i] <= 1'b1;
			end else begin
				sync[i] <= {sync[i][SYNC_STAGES-2:0], raw_in[i]};
				if (sync[i][1] == sync[i][2]) begin
					filt[i] <= sync[i][2];
				end
			end
		end
	end

	wire logic scl_f = filt[LANE_SCL];
	wire logic sda_f = filt[LANE_SDA];
	wire logic adsel = filt[LANE_ADSEL];

	// edge history of the filtered bus levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	// bus events; start and stop only count with scl high on both samples
	wire logic scl_rise   = scl_f & ~scl_prev;
	wire logic scl_fall   = ~scl_f & scl_prev;
	wire logic start_cond = scl_f & scl_prev & sda_prev & ~sda_f;
	wire logic stop_cond  = scl_f & scl_prev & ~sda_prev & sda_f;

	// byte decode
	wire logic       byte_done  = (bit_cnt == BYTE_BITS);
	wire logic       receiving  = (state == WSP_ADDR) || (state == WSP_INSTR) || (state == WSP_WDATA);
	wire logic [6:0] own_addr   = {ADDR_FIXED, adsel};
	wire logic       addr_match = (shreg[WIPER_W-1:1] == own_addr);
	wire logic       dir_read   = shreg[DIR_POS];
	wire logic       preset_req = shreg[PRESET_POS];
	wire logic       shut_req   = shreg[SHUTDOWN_POS];
	wire logic       fall_end   = scl_fall && byte_done && !ack_phase;
	wire logic       addr_end   = fall_end && (state == WSP_ADDR);
	wire logic       instr_end  = fall_end && (state == WSP_INSTR);
	wire logic       wdata_end  = fall_end && (state == WSP_WDATA);
	wire logic       ack_end    = scl_fall && ack_phase;
	wire logic       rd_start   = ack_end && (after_ack == WSP_RDATA);
	wire logic       rd_again   = scl_fall && (state == WSP_RACK) && master_ack;

	// protocol sequencer; start and stop win over any clock edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state      <= WSP_IDLE;
			after_ack  <= WSP_IDLE;
			ack_phase  <= 1'b0;
			master_ack <= 1'b0;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			sda_oe     <= 1'b0;
		end else if (start_cond) begin
			state     <= WSP_ADDR;
			ack_phase <= 1'b0;
			bit_cnt   <= 4'h0;
			sda_oe    <= 1'b0;
		end else if (stop_cond) begin
			state     <= WSP_IDLE;
			ack_phase <= 1'b0;
			sda_oe    <= 1'b0;
		end else if (scl_rise) begin
			// sample only while scl goes high, so data is taken when stable
			if (receiving && !ack_phase && !byte_done) begin
				shreg   <= {shreg[WIPER_W-2:0], sda_f};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == WSP_RDATA && !byte_done) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == WSP_RACK) begin
				master_ack <= ~sda_f;
			end
		end else if (scl_fall) begin
			// apart from start and stop, every drive change happens just after scl falls
			if (ack_phase) begin
				ack_phase <= 1'b0;
				bit_cnt   <= 4'h0;
				state     <= after_ack;
				if (after_ack == WSP_RDATA) begin
					shreg  <= wiper_setting_register;
					sda_oe <= ~wiper_setting_register[WIPER_W-1];
				end else begin
					sda_oe <= 1'b0;
				end
			end else if (addr_end) begin
				if (addr_match) begin
					ack_phase <= 1'b1;
					sda_oe    <= 1'b1;
					after_ack <= dir_read ? WSP_RDATA : WSP_INSTR;
				end else begin
					state <= WSP_IDLE;
				end
			end else if (instr_end || wdata_end) begin
				ack_phase <= 1'b1;
				sda_oe    <= 1'b1;
				after_ack <= WSP_WDATA;
			end else if (state == WSP_RDATA) begin
				if (byte_done) begin
					sda_oe <= 1'b0;
					state  <= WSP_RACK;
				end else begin
					sda_oe <= ~shreg[WIPER_W-2];
					shreg  <= {shreg[WIPER_W-2:0], 1'b0};
				end
			end else if (state == WSP_RACK) begin
				// a master ack asks for the same register once more
				bit_cnt <= 4'h0;
				if (master_ack) begin
					state  <= WSP_RDATA;
					shreg  <= wiper_setting_register;
					sda_oe <= ~wiper_setting_register[WIPER_W-1];
				end else begin
					state  <= WSP_IDLE;
					sda_oe <= 1'b0;
				end
			end
		end
	end

	// open drain: only a low is ever driven
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// shutdown updates at the end of the instruction byte, the wiper at the end of data bytes and on a preset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wiper_setting_register <= MIDSCALE;
			shutdown_bit           <= 1'b0;
		end else if (instr_end) begin
			shutdown_bit <= shut_req;
			if (preset_req) begin
				wiper_setting_register <= MIDSCALE;
			end
		end else if (wdata_end) begin
			wiper_setting_register <= shreg;
		end
	end

	// switch array code; shutdown hides the register but never alters it
	wire logic [WIPER_W-1:0] next_wiper_drive = shutdown_bit ? SHUTDOWN_CODE : wiper_setting_register;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wiper_drive <= MIDSCALE;
		end else begin
			wiper_drive <= next_wiper_drive;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// ack on match must appear one cycle after the eighth falling edge
	ack_on_match_a: assert property (addr_end && addr_match |=> sda_oe && ack_phase)
		else $error("matching address not acknowledged");

	// a mismatch releases sda and drops to idle
	mismatch_idle_a: assert property (addr_end && !addr_match |=> !sda_oe && state == WSP_IDLE)
		else $error("foreign address answered");

	start_detect_a: assert property (start_cond |=> state == WSP_ADDR && bit_cnt == 4'h0)
		else $error("start not followed by address phase");

	stop_idle_a: assert property (stop_cond |=> state == WSP_IDLE && !sda_oe)
		else $error("stop did not return to idle");

	// sda drive may only move after scl falls or at a start or stop
	sda_change_a: assert property ($changed(sda_oe) |-> $past(scl_fall || start_cond || stop_cond))
		else $error("sda drive changed outside scl low");

	preset_mid_a: assert property (instr_end && preset_req |=> wiper_setting_register == MIDSCALE)
		else $error("preset bit did not load midscale");

	shut_keep_a: assert property (instr_end && !preset_req |=> $stable(wiper_setting_register))
		else $error("instruction byte disturbed the wiper register");

	data_load_a: assert property (wdata_end |=> wiper_setting_register == $past(shreg))
		else $error("data byte not loaded into wiper");

	// shutdown hides the code within two cycles, and unhides it afterwards
	shut_drive_a: assert property (instr_end && shut_req |-> ##2 wiper_drive == SHUTDOWN_CODE)
		else $error("shutdown did not reach the switch array");

	resume_drive_a: assert property ($fell(shutdown_bit) |=> wiper_drive == $past(wiper_setting_register))
		else $error("stored value not reapplied after shutdown");

	read_msb_a: assert property (rd_start || rd_again |=> sda_oe == ~$past(wiper_setting_register[WIPER_W-1]))
		else $error("read did not start with the wiper msb");

	// idle never pulls the line, whatever ended the transaction
	idle_release_a: assert property (state == WSP_IDLE |-> !sda_oe)
		else $error("sda pulled low while idle");

	// only a start leaves idle, so a foreign address is ignored to the end
	idle_stay_a: assert property (state == WSP_IDLE && !start_cond |=> state == WSP_IDLE)
		else $error("idle left without a start");

	// while bits come in from the master the line is left alone
	rx_release_a: assert property (receiving && !ack_phase |-> !sda_oe)
		else $error("sda pulled low while receiving");

	// the master's acknowledge slot is never driven by the slave
	rack_release_a: assert property (state == WSP_RACK |-> !sda_oe)
		else $error("sda pulled low in master acknowledge slot");

	// the acknowledge lasts exactly one clock pulse
	ack_len_a: assert property (ack_phase && scl_fall |=> !ack_phase)
		else $error("acknowledge held past the ninth clock");

	// the bit counter never runs past one byte
	bit_cnt_max_a: assert property (bit_cnt <= BYTE_BITS)
		else $error("bit counter overran a byte");

	// a write address leads to the instruction byte
	write_dir_a: assert property (addr_end && addr_match && !dir_read |=> after_ack == WSP_INSTR)
		else $error("write address not followed by instruction phase");

	// a read address leads straight to data out
	read_dir_a: assert property (addr_end && addr_match && dir_read |=> after_ack == WSP_RDATA)
		else $error("read address not followed by data phase");

	// no instruction byte in a read: data follows the address ack
	read_next_a: assert property (rd_start |=> state == WSP_RDATA)
		else $error("read data did not follow the address ack");

	// a master ack reloads the same stored value
	read_again_a: assert property (rd_again |=> state == WSP_RDATA && shreg == $past(wiper_setting_register))
		else $error("repeated read did not reload the wiper");

	// master ack level is taken on the ninth rising edge
	master_ack_a: assert property (scl_rise && state == WSP_RACK |=> master_ack == !$past(sda_f))
		else $error("master acknowledge not captured");

	// the shutdown flag follows the instruction byte
	shut_load_a: assert property (instr_end |=> shutdown_bit == $past(shut_req))
		else $error("shutdown bit not taken from instruction");

	// data bytes never touch the shutdown state
	shut_hold_a: assert property (wdata_end |=> $stable(shutdown_bit))
		else $error("data byte changed shutdown state");

	// the register only moves at the end of an instruction or data byte
	wiper_quiet_a: assert property (!instr_end && !wdata_end |=> $stable(wiper_setting_register))
		else $error("wiper register changed outside a byte end");

	// in shutdown the switch array sees the b terminal code
	shut_code_a: assert property (shutdown_bit |=> wiper_drive == SHUTDOWN_CODE)
		else $error("shutdown code not applied");

	// out of shutdown the switch array follows the register one cycle late
	drive_follow_a: assert property (!shutdown_bit |=> wiper_drive == $past(wiper_setting_register))
		else $error("switch array not following the register");

	// open drain: the driven value is always low
	drain_low_a: assert property (sda_out == 1'b0)
		else $error("sda driven high");

	cov_preset_c:   cover property (instr_end && preset_req);
	cov_write_c:    cover property (wdata_end ##[1:1000] stop_cond);
	cov_read_c:     cover property (rd_start ##[1:1000] rd_again);
	cov_shutdown_c: cover property (instr_end && shut_req);
	cov_foreign_c:  cover property (addr_end && !addr_match);
endmodule : wsp_serial_slave
`default_nettype wire

// >>> wsp_bus_master.sv
// two-wire bus master model: drives the bus clock and pulls data low
`timescale 1ns/100ps
`default_nettype none
module wsp_bus_master #(
	parameter int Q = 250
) (
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda
);
	// bus idle: clock high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one clock pulse; data changes mid-low and is read mid-high
	task automatic bit_io(input logic b, output logic r);
		#Q sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask : bit_io
	// release data, raise clock, pull data low; also serves as repeated start
	task automatic start();
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
	endtask : start
	// data low while clock low, so releasing it with clock high forms the stop
	task automatic stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask : stop
	// eight bits msb first, then the ninth clock for the acknowledge
	task automatic xbyte(input logic [7:0] d, input logic ack_tx, output logic [7:0] q, output logic ack_rx);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_tx, ack_rx);
	endtask : xbyte
endmodule : wsp_bus_master
`default_nettype wire

// >>> wsp_serial_slave_test.sv
// self-checking bench for the wiper serial slave port
`timescale 1ns/100ps
`default_nettype none
module wsp_serial_slave_test;
	import wsp_pkg::*;
	// fixed address part, arbitrary value
	localparam logic [ADDR_FIXED_W-1:0] ADR = 6'h16;
	logic               clk;
	logic               resetn;
	logic               addr_select_pin;
	logic               scl;
	logic               sda_low;
	logic               sda_out;
	logic               sda_oe;
	logic               shutdown_bit;
	logic [WIPER_W-1:0] wiper_setting_register;
	logic [WIPER_W-1:0] wiper_drive;
	int                 num_errors;
	int                 comparisons;
	// wired-and bus line with pull-up
	wire                sda = !sda_low && !(sda_oe && !sda_out);

	wsp_serial_slave #(.ADDR_FIXED(ADR)) i_dut (
		.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_select_pin(addr_select_pin), .wiper_setting_register(wiper_setting_register),
		.shutdown_bit(shutdown_bit), .wiper_drive(wiper_drive)
	);
	// slower bus clock than 200 ns so the acknowledge settles before the master samples
	wsp_bus_master #(.Q(250)) i_m (.scl(scl), .sda_low(sda_low), .sda(sda));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test

	// write: address, instruction, nd data bytes (alternately d and ~d), stop
	task automatic wr(input logic sel, input logic [7:0] ins, input logic [7:0] d, input int nd, input logic e);
		logic [7:0] x;
		logic       a;
		i_m.start();
		i_m.xbyte({ADR, sel, 1'b0}, 1'b1, x, a);
		chk({7'h0, a}, {7'h0, e});
		i_m.xbyte(ins, 1'b1, x, a);
		for (int j = 0; j < nd; j++) begin
			i_m.xbyte(d ^ {8{j[0]}}, 1'b1, x, a);
		end
		i_m.stop();
		repeat (8) @(posedge clk);
	endtask : wr

	// read n bytes, master acks all but the last
	task automatic rd(input logic sel, input logic [7:0] e, input int n);
		logic [7:0] x;
		logic       a;
		i_m.start();
		i_m.xbyte({ADR, sel, 1'b1}, 1'b1, x, a);
		chk({7'h0, a}, 8'h00);
		for (int j = 0; j < n; j++) begin
			i_m.xbyte(8'hff, j == n - 1, x, a);
			chk(x, e);
		end
		i_m.stop();
		repeat (8) @(posedge clk);
	endtask : rd

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	initial begin
		resetn = 1'b0;
		addr_select_pin = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		chk(wiper_setting_register, MIDSCALE);
		chk(wiper_drive, MIDSCALE);
		chk({7'h0, shutdown_bit}, 8'h00);
		chk({7'h0, sda_out}, 8'h00);
		wr(1'b0, 8'h00, 8'h5a, 2, 1'b0);
		chk(wiper_setting_register, 8'ha5);
		chk(wiper_drive, 8'ha5);
		rd(1'b0, 8'ha5, 3);
		// shutdown with every ignored instruction bit set
		wr(1'b0, 8'hbf, 8'h3c, 1, 1'b0);
		chk({7'h0, shutdown_bit}, 8'h01);
		chk(wiper_drive, SHUTDOWN_CODE);
		chk(wiper_setting_register, 8'h3c);
		rd(1'b0, 8'h3c, 1);
		wr(1'b0, 8'h00, 8'h00, 0, 1'b0);
		chk({7'h0, shutdown_bit}, 8'h00);
		chk(wiper_drive, 8'h3c);
		wr(1'b0, 8'h40, 8'h00, 0, 1'b0);
		chk(wiper_setting_register, MIDSCALE);
		wr(1'b0, 8'h00, 8'h00, 0, 1'b0);
		chk(wiper_drive, MIDSCALE);
		// wrong select bit is ignored, then the pin moves the address
		wr(1'b1, 8'h00, 8'h11, 1, 1'b1);
		chk(wiper_setting_register, MIDSCALE);
		@(posedge clk) addr_select_pin <= 1'b1;
		repeat (8) @(posedge clk);
		wr(1'b1, 8'h00, 8'h11, 1, 1'b0);
		wr(1'b0, 8'h00, 8'h22, 1, 1'b1);
		chk(wiper_setting_register, 8'h11);
		rd(1'b1, 8'h11, 2);
		stop_test();
	end
endmodule : wsp_serial_slave_test
`default_nettype wire
